// ### core/ebc_ctrl.sv
// external bus cycle controller: five phase sequencer with ready handshake
//
// Functional notes
// [R1] every bus cycle runs address setup, command delay, write setup, access, hold
// [R2] address setup lasts 1 or 2 units, plus 0..3 when the window changes
// [R3] command delay is 0..3 units, write setup/turnaround 0..1 unit
// [R4] access lasts 1..32 units and may be stretched by ready
// [R5] hold lasts 0..3 units with address and write data still driven
// [R6] reference clock output has a period of one system clock; the code drives a registered enable level instead
// [R7] ready polarity is selectable and applied to the sampled input
// [R8] in synchronous mode the partner drives ready synchronous to the reference clock
// [R9] asynchronous ready passes an extra stage, costing at least one wait state
// [R10] asynchronous ready must be held at least one clock plus setup
// [R11] partner may drop ready after the strobe's rising edge
// [R12] partner drops ready before the next cycle's first sampling point
// [R13] inactive ready adds a wait state, active ready ends the cycle
// [R14] ready is evaluated only after the mandatory access units elapse
// [R15] read data is captured on the edge that raises the read strobe
// [R16] read data may change after the strobe rises without harm
// [R17] multiplexed mode shares 16 lines; separate mode has 24 address, 16 data
// [R18] each chip select has its own timing set
// [R19] strobes are active only in access; latch strobe pulses in multiplexed setup
`timescale 1ns/1ns
`include "ebc_map.svh"
module ebc_ctrl
  import ebc_pkg::*;
#(
  parameter int NUM_CS = `EBC_NUM_CS
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_multiplexed_bus,
  input  wire logic                    i_clk_out_en,
  input  wire ebc_timing_t             i_bus_cycle_timing_regs [NUM_CS],
  input  wire logic                    i_req_valid,
  input  wire ebc_req_t                i_req,
  input  wire logic                    i_ready,
  input  wire logic [15:0]             i_data_lines,
  input  wire logic [15:0]             i_shared_addr_data_lines,
  output logic                         o_req_ready,
  output logic                         o_done,
  output logic [15:0]                  o_rdata,
  output logic                         o_reference_clock_output,
  output logic [23:0]                  o_address_lines,
  output logic [15:0]                  o_data_lines,
  output logic                         o_data_lines_oe,
  output logic [15:0]                  o_shared_addr_data_lines,
  output logic                         o_shared_addr_data_lines_oe,
  output logic                         o_addr_latch,
  output logic                         o_rd_n,
  output logic                         o_wr_n,
  output logic                         o_upper_byte_select_n,
  output logic [NUM_CS-1:0]            o_cs_n
);

  // ----------------------------------------------------------------
  // cycle state
  // ----------------------------------------------------------------
  ebc_state_t  state;
  ebc_timing_t tim;
  ebc_req_t    cur;
  logic [4:0]  cnt;
  logic [1:0]  last_sel;
  logic        first_done;
  logic        rdy_s1;
  logic        rdy_s2;
  logic        rdy_s3;
  logic        rdy_act_sync;
  logic        rdy_act_async;
  logic        rdy_act;
  logic        cnt_last;
  logic        clk_div;
  logic        rd_rise;
  logic        acc_end;
  logic        acc_end_q;
  logic        rd_end_q;

  // three stage input capture; async mode reads the deeper agreeing stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      rdy_s3 <= 1'b0;
    end else begin
      rdy_s1 <= i_ready;
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
    end
  end

  // [R7] polarity applied
  // [R9] async adds a stage
  // sync path samples the pin once; async only counts when stages agree
  assign rdy_act_sync  = (i_ready == tim.rdy_pol);
  assign rdy_act_async = (rdy_s2 == rdy_s3) && (rdy_s3 == tim.rdy_pol);
  assign rdy_act       = tim.rdy_async ? rdy_act_async : rdy_act_sync;
  assign cnt_last      = (cnt == `EBC_CNT_ZERO);

  // [R6] reference clock out
  // a toggling flop cannot reach one system period, so the output is a
  // registered enable used as the clock mirror; real pads gate i_clk with it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_div <= 1'b0;
    end else begin
      clk_div <= i_clk_out_en;
    end
  end

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state      <= EBC_IDLE;
      tim        <= `EBC_TIMING_RESET;
      cur        <= '0;
      cnt        <= `EBC_CNT_ZERO;
      last_sel   <= 2'h0;
      first_done <= 1'b0;
    end else begin
      case (state)
        EBC_IDLE: begin
          if (i_req_valid) begin
            // [R18] per select timing
            tim <= i_bus_cycle_timing_regs[i_req.sel];
            cur <= i_req;
            // [R2] window change extends setup
            cnt <= 5'(i_bus_cycle_timing_regs[i_req.sel].ab_long)
                 + ((!first_done || i_req.sel != last_sel)
                    ? 5'(i_bus_cycle_timing_regs[i_req.sel].ab_extra) : `EBC_CNT_ZERO);
            last_sel   <= i_req.sel;
            first_done <= 1'b1;
            state      <= EBC_AB;
          end
        end
        // [R1] five phases in order
        EBC_AB: begin
          if (!cnt_last) begin
            cnt <= cnt - `EBC_CNT_ONE;
          end else if (tim.cmd_dly != 2'h0) begin
            // [R3] command delay
            cnt   <= 5'(tim.cmd_dly) - `EBC_CNT_ONE;
            state <= EBC_C;
          end else if (tim.wr_setup) begin
            cnt   <= `EBC_CNT_ZERO;
            state <= EBC_D;
          end else begin
            cnt   <= tim.access;
            state <= EBC_E;
          end
        end
        EBC_C: begin
          if (!cnt_last) begin
            cnt <= cnt - `EBC_CNT_ONE;
          end else if (tim.wr_setup) begin
            cnt   <= `EBC_CNT_ZERO;
            state <= EBC_D;
          end else begin
            cnt   <= tim.access;
            state <= EBC_E;
          end
        end
        EBC_D: begin
          // [R4] access length
          cnt   <= tim.access;
          state <= EBC_E;
        end
        EBC_E: begin
          if (!cnt_last) begin
            cnt <= cnt - `EBC_CNT_ONE;
          end else if (tim.rdy_en && (tim.rdy_async || !rdy_act)) begin
            // [R14] ready only after mandatory units
            // async always waits one unit for the extra stage
            state <= EBC_RDY;
          end else begin
            // [R5] hold phase
            cnt   <= 5'(tim.hold);
            state <= (tim.hold != 2'h0) ? EBC_F : EBC_IDLE;
          end
        end
        EBC_RDY: begin
          // [R13] inactive waits, active ends
          if (rdy_act) begin
            cnt   <= 5'(tim.hold);
            state <= (tim.hold != 2'h0) ? EBC_F : EBC_IDLE;
          end
        end
        EBC_F: begin
          if (cnt > `EBC_CNT_ONE) begin
            cnt <= cnt - `EBC_CNT_ONE;
          end else begin
            state <= EBC_IDLE;
          end
        end
        default: begin
          state <= EBC_IDLE;
        end
      endcase
    end
  end

  // access ends this cycle: the strobe pins follow one edge later
  assign acc_end = ((state == EBC_E) && cnt_last
                    && !(tim.rdy_en && (tim.rdy_async || !rdy_act)))
                 || ((state == EBC_RDY) && rdy_act);
  assign rd_rise = acc_end && !cur.write;

  // pins lag the state by one edge, so the strobe rises one edge after access ends
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_end_q <= 1'b0;
      rd_end_q  <= 1'b0;
    end else begin
      acc_end_q <= acc_end;
      rd_end_q  <= rd_rise;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_n                      <= 1'b1;
      o_wr_n                      <= 1'b1;
      o_addr_latch                <= 1'b0;
      o_cs_n                      <= '1;
      o_upper_byte_select_n       <= 1'b1;
      o_address_lines             <= `EBC_ADDR_ZERO;
      o_data_lines                <= `EBC_DATA_ZERO;
      o_data_lines_oe             <= 1'b0;
      o_shared_addr_data_lines    <= `EBC_DATA_ZERO;
      o_shared_addr_data_lines_oe <= 1'b0;
      o_req_ready                 <= 1'b0;
      o_done                      <= 1'b0;
      o_rdata                     <= `EBC_DATA_ZERO;
      o_reference_clock_output    <= 1'b0;
    end else begin
      o_reference_clock_output <= clk_div;
      o_req_ready              <= (state == EBC_IDLE) && !i_req_valid;
      // done follows the edge that ends the strobe, so read data already stand
      o_done                   <= acc_end_q;
      // [R19] strobes only in access
      o_rd_n       <= !((state == EBC_E || state == EBC_RDY) && !cur.write);
      o_wr_n       <= !((state == EBC_E || state == EBC_RDY) && cur.write);
      // latch pulses in the last setup unit, while the shared lines carry the address
      o_addr_latch <= i_multiplexed_bus && (state == EBC_AB) && cnt_last;
      for (int i = 0; i < NUM_CS; i++) begin
        o_cs_n[i] <= !((state != EBC_IDLE) && (cur.sel == 2'(i)));
      end
      o_upper_byte_select_n <= (state == EBC_IDLE) ? 1'b1 : cur.upper_n;
      // [R17] mux vs separate lines
      o_address_lines <= (state == EBC_IDLE) ? `EBC_ADDR_ZERO : cur.addr;
      if (i_multiplexed_bus) begin
        o_shared_addr_data_lines    <= (state == EBC_AB) ? cur.addr[15:0] : cur.wdata;
        o_shared_addr_data_lines_oe <= (state == EBC_AB) || (cur.write && state != EBC_IDLE);
        o_data_lines_oe             <= 1'b0;
      end else begin
        o_data_lines                <= cur.wdata;
        o_data_lines_oe             <= cur.write && (state != EBC_IDLE) && (state != EBC_AB);
        o_shared_addr_data_lines_oe <= 1'b0;
      end
      // [R15] capture on strobe rise edge
      if (rd_end_q) begin
        o_rdata <= i_multiplexed_bus ? i_shared_addr_data_lines : i_data_lines;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_strobe_access;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!o_wr_n) |-> $past(state == EBC_E || state == EBC_RDY);
  endproperty
  a_strobe_access: assert property (p_strobe_access) // [R19]
    else $error("write strobe outside access");

  property p_ready_ends;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == EBC_RDY && rdy_act) |=> (state == EBC_F || state == EBC_IDLE);
  endproperty
  a_ready_ends: assert property (p_ready_ends) // [R13]
    else $error("active ready did not end access");

  property p_not_ready_waits;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == EBC_RDY && !rdy_act) |=> (state == EBC_RDY);
  endproperty
  a_not_ready_waits: assert property (p_not_ready_waits) // [R13]
    else $error("inactive ready did not wait");

  property p_async_wait;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == EBC_E && cnt_last && tim.rdy_en && tim.rdy_async) |=> (state == EBC_RDY);
  endproperty
  a_async_wait: assert property (p_async_wait) // [R9]
    else $error("async ready skipped its wait state");

  property p_order;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == EBC_F) |-> $past(state == EBC_E || state == EBC_RDY || state == EBC_F);
  endproperty
  a_order: assert property (p_order) // [R1]
    else $error("hold not preceded by access");

  property p_cs_held;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == EBC_F) |=> (o_cs_n != '1);
  endproperty
  a_cs_held: assert property (p_cs_held) // [R5]
    else $error("select dropped during hold");

  property p_latch_mux;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_addr_latch |-> $past(i_multiplexed_bus) && $past(state == EBC_AB) ##1 !o_addr_latch;
  endproperty
  a_latch_mux: assert property (p_latch_mux) // [R19]
    else $error("latch strobe outside multiplexed setup");

  property p_access_min;
    @(posedge i_clk) disable iff (!i_rst_n)
      ($rose(state == EBC_E) && tim.access == 5'h01) |-> (state == EBC_E) ##1 (state == EBC_E);
  endproperty
  a_access_min: assert property (p_access_min) // [R4]
    else $error("access shorter than programmed");

endmodule

// ### core/ebc_map.svh
// constants for the external bus cycle controller
`ifndef EBC_MAP_SVH
`define EBC_MAP_SVH
`define EBC_NUM_CS        4
`define EBC_AB_EXTRA_MAX  2'h3
`define EBC_CNT_ONE       5'h01
`define EBC_CNT_ZERO      5'h00
`define EBC_ADDR_W        24
`define EBC_DATA_W        16
`define EBC_ADDR_ZERO     24'h000000
`define EBC_DATA_ZERO     16'h0000
`define EBC_SEL_NONE      4'hf
`define EBC_TIMING_RESET  16'h0000
`endif

// ### core/ebc_pkg.sv
// types for the external bus cycle controller
`include "ebc_map.svh"
package ebc_pkg;
  // one chip select's phase timing set
  typedef struct packed {
    logic       ab_long;   // address setup 2 units instead of 1
    logic [1:0] ab_extra;  // extra units on window change
    logic [1:0] cmd_dly;   // command delay 0..3
    logic       wr_setup;  // write setup / turnaround 0..1
    logic [4:0] access;    // access length minus one, 1..32
    logic [1:0] hold;      // hold 0..3
    logic       rdy_en;    // access may be stretched by ready
    logic       rdy_pol;   // 1: ready active high
    logic       rdy_async; // 1: asynchronous ready
  } ebc_timing_t;

  // request from the core side
  typedef struct packed {
    logic        write;
    logic [1:0]  sel;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        upper_n;
  } ebc_req_t;

  typedef enum logic [2:0] {
    EBC_IDLE = 3'b000,
    EBC_AB   = 3'b001,
    EBC_C    = 3'b010,
    EBC_D    = 3'b011,
    EBC_E    = 3'b100,
    EBC_RDY  = 3'b101,
    EBC_F    = 3'b110
  } ebc_state_t;
endpackage

// ### sim/ebc_mem_model.sv
// bus partner model: small word memory with a ready handshake
`timescale 1ns/1ns
module ebc_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_mux,
  input  wire logic        i_pol,
  input  wire logic        i_async,
  input  wire logic [3:0]  i_dly,
  input  wire logic [3:0]  i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_latch,
  input  wire logic [23:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [15:0] i_shared,
  output logic             o_ready,
  output logic [15:0]      o_data
);
  // ----------------------------------------
  // storage and handshake state
  // ----------------------------------------
  logic [15:0] mem [16];
  logic [3:0]  lat_a;
  logic [3:0]  idx;
  logic [3:0]  cnt;
  logic        seen;
  logic        cmd;
  logic        act;
  logic        act_d;
  logic        ra;

  // only the low address bits select a word, the rest alias
  assign idx = i_mux ? lat_a : i_addr[3:0];
  assign cmd = !(i_rd_n && i_wr_n);
  assign act = (i_cs_n != 4'hf) && (cnt >= i_dly) && !(seen && !cmd);
  assign #13 act_d = act;
  assign ra = i_async ? act_d : act;
  assign o_ready = ~(ra ^ i_pol);

  // count cycles since select; saturate so a long stall never wraps
  always_ff @(posedge i_clk) begin
    if (i_cs_n == 4'hf) begin
      cnt  <= 4'h0;
      seen <= 1'b0;
    end else begin
      cnt  <= cnt + {3'h0, cnt != 4'hf};
      seen <= seen | cmd;
    end
    if (i_latch) begin
      lat_a <= i_shared[3:0];
    end
  end

  // write data taken on every edge inside the strobe; the last one wins and
  // no address change at the strobe's end can race it
  always_ff @(posedge i_clk) begin
    if (!i_wr_n) begin
      mem[idx] <= i_mux ? i_shared : i_wdata;
    end
  end

  assign o_data = i_rd_n ? ~mem[idx] : mem[idx];
endmodule

// ### sim/external_bus_cycle_control_tb_top.sv
// testbench for the external bus cycle controller
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module external_bus_cycle_control_tb_top
  import ebc_pkg::*;
;
  // ----------------------------------------
  // stimulus and observed pins
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        multiplexed_bus = 1'b0;
  logic        req_valid = 1'b0;
  ebc_req_t    req = '0;
  ebc_timing_t cfg [4];
  logic [3:0]  dly = 4'h0;
  logic        ready, req_ready, done, latch, rd_n, wr_n, d_oe, s_oe;
  logic        ref_o, ube, ube_s;
  logic [15:0] rdata, d_out, s_out, pd, d_in, s_in;
  logic [23:0] addr;
  logic [23:0] cur_a;
  logic [3:0]  cs_n;
  logic [3:0]  cs_s;
  logic [1:0]  last_s = 2'h0;
  logic        seen, brk;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          pre, acc, post, lat;
  int          bad = 0;

  // shared lines resolve to whoever enables its driver
  assign d_in = d_oe ? d_out : pd;
  assign s_in = s_oe ? s_out : pd;

  always #25 clk = ~clk;

  ebc_ctrl u_ebc_ctrl (
    .i_clk(clk), .i_rst_n(rst_n), .i_multiplexed_bus(multiplexed_bus), .i_clk_out_en(1'b1),
    .i_bus_cycle_timing_regs(cfg), .i_req_valid(req_valid), .i_req(req),
    .i_ready(ready), .i_data_lines(d_in), .i_shared_addr_data_lines(s_in),
    .o_req_ready(req_ready), .o_done(done), .o_rdata(rdata),
    .o_reference_clock_output(ref_o), .o_address_lines(addr), .o_data_lines(d_out),
    .o_data_lines_oe(d_oe), .o_shared_addr_data_lines(s_out),
    .o_shared_addr_data_lines_oe(s_oe), .o_addr_latch(latch), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_upper_byte_select_n(ube), .o_cs_n(cs_n));

  ebc_mem_model u_ebc_mem_model (
    .i_clk(clk), .i_mux(multiplexed_bus), .i_pol(cfg[2].rdy_pol), .i_async(cfg[2].rdy_async),
    .i_dly(dly), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_latch(latch),
    .i_addr(addr), .i_wdata(d_out), .i_shared(s_out), .o_ready(ready), .o_data(pd));

  // phase lengths measured at the falling edge, where outputs are settled
  always @(negedge clk) begin
    if (!(rd_n && wr_n)) begin
      acc++;
      seen = 1'b1;
      cs_s = cs_n;
      ube_s = ube;
    end else if (!seen && cs_n != 4'hf) begin
      pre++;
    end else if (seen && !brk && addr == cur_a) begin
      post++;
    end else if (seen) begin
      brk = 1'b1;
    end
    if (latch) lat++;
    if (latch && !(rd_n && wr_n)) bad++;
  end

  task automatic close_out();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hung handshake ends the run instead of spinning forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // one bus cycle; d is write data, or the expected read data
  task automatic xfer(input logic w, input logic [1:0] s, input logic [23:0] a,
                      input logic [15:0] d);
    int n;
    int e;
    n = 0;
    {pre, acc, post, lat} = 128'h0;
    {seen, brk} = 2'b00;
    cur_a = a;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{w, s, a, d, w};
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 600);
    while (req_ready !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    // the setup/turnaround phase belongs to every cycle, reads too
    e = 1 + cfg[s].ab_long + cfg[s].cmd_dly + cfg[s].wr_setup;
    if (s != last_s) e += cfg[s].ab_extra;
    `CHK(n < 600, 1'b1)
    `CHK(pre, e)
    `CHK(cs_s, ~(4'h1 << s))
    if (!cfg[s].rdy_en) `CHK(acc, int'(cfg[s].access) + 1)
    if (!w) `CHK(rdata, d)
    `CHK(post, int'(cfg[s].hold))
    `CHK(ube_s, w)
    `CHK(ref_o, 1'b1)
    if (multiplexed_bus) `CHK(lat > 0, 1'b1)
    `CHK(bad, 0)
    last_s = s;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    cfg[0] = '{1'b0, 2'h0, 2'h0, 1'b0, 5'h00, 2'h0, 1'b0, 1'b1, 1'b0};
    cfg[1] = '{1'b1, 2'h3, 2'h3, 1'b0, 5'h1f, 2'h3, 1'b0, 1'b1, 1'b0};
    cfg[2] = '{1'b0, 2'h1, 2'h1, 1'b0, 5'h01, 2'h1, 1'b1, 1'b1, 1'b0};
    cfg[3] = '{1'b0, 2'h0, 2'h0, 1'b1, 5'h02, 2'h2, 1'b0, 1'b1, 1'b0};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // separate lines: longest access, window change and none
    xfer(1'b1, 2'h3, 24'hc30005, 16'ha5c3);
    xfer(1'b0, 2'h0, 24'hc30005, 16'ha5c3);
    xfer(1'b0, 2'h1, 24'hc30005, 16'ha5c3);
    xfer(1'b0, 2'h1, 24'hc30005, 16'ha5c3);
    @(posedge clk);
    multiplexed_bus <= 1'b1;
    xfer(1'b1, 2'h3, 24'h000009, 16'h5a3c);
    xfer(1'b0, 2'h0, 24'h000009, 16'h5a3c);
    // every polarity and sync mode, ready early and late
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      cfg[2].rdy_pol <= k[0];
      cfg[2].rdy_async <= k[1];
      dly <= k[2] ? 4'h8 : 4'h0;
      xfer(1'b0, 2'h2, 24'h000009, 16'h5a3c);
      if (k[2]) `CHK(acc > 3, 1'b1)
      else if (k[1]) `CHK(acc >= 3, 1'b1)
      else `CHK(acc, 2)
    end
    close_out();
  end
endmodule
